//--- bench/lcs_pwm_src.sv
/*
  Stand-in for the external PWM oscillator that times the ramps.
  Assumes a 1 ns time unit; it runs free, as the oscillator does.
*/
`timescale 1ns/1ns
module lcs_pwm_src #(
  parameter int P_HALF_NS = 40
)(
  output logic o_pwm_clk
);
  // Phase offset keeps its edges away from the system clock edges
  initial
  begin
    o_pwm_clk = 1'b0;
    #3;
    forever #(P_HALF_NS) o_pwm_clk = ~o_pwm_clk;
  end
endmodule : lcs_pwm_src

//--- bench/lcs_top_tb.sv
/*
  Self-checking bench for lcs_top: register bank and ramp sequencer.
  Assumes hw/ on the include path; ramp step shortened to 2 PWM ticks.
*/
`timescale 1ns/1ns
module lcs_top_tb;
  import lcs_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  lcs_wr_t i_wr = '0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_rd_addr = 8'h00;
  logic i_shdn_req = 1'b0;
  logic i_wake_req = 1'b0;
  logic i_pwm_clk;
  logic [7:0] o_rd_data;
  logic o_rd_valid;
  logic [9:0] o_port_full;
  logic [2:0] o_full_scale_code;
  logic [2:0] o_ref_code;
  lcs_status_t o_status;
  int miscompares = 0;
  int checks_done = 0;
  int n;

  always #5 i_mclk = ~i_mclk;

  lcs_top #(.P_STEP_TICKS(18'h2)) u_lcs_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr(i_wr),
    .i_rd_en(i_rd_en), .i_rd_addr(i_rd_addr), .i_pwm_clk(i_pwm_clk), .i_shdn_req(i_shdn_req),
    .i_wake_req(i_wake_req), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_port_full(o_port_full), .o_full_scale_code(o_full_scale_code),
    .o_ref_code(o_ref_code), .o_status(o_status));
  lcs_pwm_src u_lcs_pwm_src (.o_pwm_clk(i_pwm_clk));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr = '{en: 1'b1, addr: a, data: d};
    tick(1);
    i_wr.en = 1'b0;
    // Idle edge so a following write never re-raises the strobe in this time step
    tick(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_rd_en = 1'b1;
    i_rd_addr = a;
    tick(1);
    i_rd_en = 1'b0;
    chk("read valid", {7'h00, o_rd_valid}, 8'h01);
    chk("read data", o_rd_data, exp);
    tick(1);
    chk("read valid drop", {7'h00, o_rd_valid}, 8'h00);
  endtask : rd

  // Only the raised request is lowered, so back-to-back calls never assign one signal twice
  task automatic req(input logic shdn);
    if (shdn)
    begin
      i_shdn_req = 1'b1;
      tick(1);
      i_shdn_req = 1'b0;
    end
    else
    begin
      i_wake_req = 1'b1;
      tick(1);
      i_wake_req = 1'b0;
    end
  endtask : req

  // Bounded wait on the sequencer state; running out ends the run
  task automatic wait_st(input logic [3:0] exp, input string what, output int k);
    k = 0;
    while (o_status !== exp && k < 1000)
    begin
      tick(1);
      k++;
    end
    chk(what, {4'h0, o_status}, {4'h0, exp});
    if (k == 1000)
    begin
      miscompares++;
      results();
    end
  endtask : wait_st

  task automatic t_reset();
    chk("full scale", {5'h00, o_full_scale_code}, 8'h07);
    chk("status", {4'h0, o_status}, 8'h01);
    rd(8'h15, 8'h07);
  endtask : t_reset

  task automatic t_regs();
    wr(8'h13, 8'hA5);
    chk("ports low", o_port_full[7:0], 8'hA5);
    rd(8'h13, 8'hA5);
    wr(8'h14, 8'hFF);
    chk("ports high", {6'h00, o_port_full[9:8]}, 8'h03);
    rd(8'h14, 8'h03);
    wr(8'h15, 8'hFA);
    chk("full scale", {5'h00, o_full_scale_code}, 8'h02);
    rd(8'h15, 8'h02);
    wr(8'h13, 8'h5A);
    chk("ports low", o_port_full[7:0], 8'h5A);
    rd(8'h20, 8'h00);
  endtask : t_regs

  task automatic t_instant();
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    req(1'b0);
    chk("status", {4'h0, o_status}, 8'h00);
    chk("ref", {5'h00, o_ref_code}, 8'h02);
    req(1'b1);
    wait_st(4'h1, "shutdown", n);
  endtask : t_instant

  task automatic t_ramp();
    wr(8'h15, 8'h07);
    wr(8'h11, 8'hC9);
    wr(8'h12, 8'hF9);
    rd(8'h11, 8'h09);
    rd(8'h12, 8'h01);
    req(1'b0);
    chk("status", {4'h0, o_status}, 8'h02);
    wait_st(4'h0, "active", n);
    chk("ref", {5'h00, o_ref_code}, 8'h07);
    req(1'b1);
    chk("status", {4'h0, o_status}, 8'h08);
    chk("ref", {5'h00, o_ref_code}, 8'h07);
    wait_st(4'h4, "fade", n);
    // 16 ticks of 80 ns each, give or take the synchroniser
    chk("hold time", {7'h00, n >= 100 && n <= 160}, 8'h01);
    wait_st(4'h1, "shutdown", n);
    chk("ref", {5'h00, o_ref_code}, 8'h00);
    wr(8'h15, 8'h03);
    req(1'b0);
    wait_st(4'h0, "active", n);
    chk("ref", {5'h00, o_ref_code}, 8'h03);
  endtask : t_ramp

  // Skipped hold-off, a longer fade code, and a shutdown cut into a ramp-up
  task automatic t_paths();
    wr(8'h11, 8'h02);
    req(1'b1);
    chk("status", {4'h0, o_status}, 8'h04);
    chk("ref", {5'h00, o_ref_code}, 8'h03);
    wait_st(4'h1, "shutdown", n);
    // 8 steps of 4 ticks at 8 cycles per tick
    chk("fade time", {7'h00, n >= 240 && n <= 270}, 8'h01);
    wr(8'h11, 8'h08);
    req(1'b0);
    chk("status", {4'h0, o_status}, 8'h02);
    req(1'b1);
    chk("status", {4'h0, o_status}, 8'h08);
    chk("ref", {5'h00, o_ref_code}, 8'h03);
    wait_st(4'h1, "shutdown", n);
    chk("ref", {5'h00, o_ref_code}, 8'h00);
  endtask : t_paths

  initial
  begin
    tick(4);
    i_rst_n = 1'b1;
    t_reset();
    t_regs();
    t_instant();
    t_ramp();
    t_paths();
    results();
  end
endmodule : lcs_top_tb

//--- hw/lcs_pkg.sv
/*
  Types for the LED sink current settings block.
  Includes nothing; lcs_regs.svh is used by the block only.
*/
package lcs_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_HOLD,
    ST_FADE,
    ST_SHDN,
    ST_RAMPUP
  } lcs_state_t;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } lcs_wr_t;

  typedef struct packed {
    logic holdoff;
    logic fadeoff;
    logic rampup;
    logic shutdown;
  } lcs_status_t;
endpackage : lcs_pkg

//--- hw/lcs_regs.svh
/*
  Register offsets, field positions, reset values and ramp timing for the
  LED sink current settings block. Definitions only; included by the
  block only, not by the package.
*/
`ifndef LCS_REGS_SVH
`define LCS_REGS_SVH

`define LCS_ADDR_RAMP_DOWN 8'h11
`define LCS_ADDR_RAMP_UP 8'h12
`define LCS_ADDR_SEL_LOW 8'h13
`define LCS_ADDR_SEL_HIGH 8'h14
`define LCS_ADDR_FULL_SCALE 8'h15

`define LCS_HOLD_MSB 5
`define LCS_HOLD_LSB 3
`define LCS_CODE_MSB 2
`define LCS_CODE_LSB 0

`define LCS_RST_SEL_LOW 8'h00
`define LCS_RST_SEL_HIGH 2'h0
`define LCS_RST_FULL_SCALE 3'h7
`define LCS_RST_RAMP 3'h0

`define LCS_PWM_HZ 32768
`define LCS_BASE_DIV 16
`define LCS_STEPS 8
`define LCS_STEP_TICKS ((`LCS_PWM_HZ / `LCS_BASE_DIV) / `LCS_STEPS)

`endif

//--- hw/lcs_top.sv
/*
  Current-setting register bank with the automatic ramp-down / ramp-up
  sequencer that drives the 3-bit reference scaling code.
  Assumes a register write/read port already decoded from the serial
  interface on i_mclk, and a free-running PWM clock arriving as a pin.
*/
`timescale 1ns/1ns
`include "lcs_regs.svh"

// Functional notes
// - Register 0x13 holds the half/full select bit of ports 0 to 7, bit n for port n, 1 = full.
// - Register 0x14 holds port 8 in bit 0 and port 9 in bit 1, upper bits ignored and read zero.
// - Bits 2:0 of register 0x15 set full current from 2.5mA (000) to 20mA (111) in equal steps.
// - A port on half sinks exactly half the full current, a port on full sinks the full current.
// - After reset the full-current code is 111, so half ports sink 10mA.
// - Half/full bits may change while outputs run and take effect at once.
// - A ramp-down request reduces the currents and enters shutdown with no further host action.
// - Leaving shutdown raises the currents back automatically.
// - Ramp-down runs a hold-off at full current, then the fade-off during which currents fall.
// - Register 0x11 holds hold-off in bits 5:3 and fade-off in bits 2:0; 000 is instant, else 1/16s doubling to 4s.
// - Register 0x12 holds the ramp-up code in bits 2:0; 000 is instant, else 1/16s doubling to 4s.
// - All ramp durations are counted in PWM clock periods, assuming 32768Hz.
// - The ramp steps a 3-bit scale on the master reference, bounded by the full-current code.
module lcs_top
  import lcs_pkg::*;
#(
  parameter logic [17:0] P_STEP_TICKS = 18'(`LCS_STEP_TICKS)
)(
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire lcs_wr_t i_wr,
  input wire logic i_rd_en,
  input wire logic [7:0] i_rd_addr,
  input wire logic i_pwm_clk,
  input wire logic i_shdn_req,
  input wire logic i_wake_req,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic [9:0] o_port_full,
  output logic [2:0] o_full_scale_code,
  output logic [2:0] o_ref_code,
  output lcs_status_t o_status
);

  logic [7:0] sel_low, next_sel_low;
  logic [1:0] sel_high, next_sel_high;
  logic [2:0] iset, next_iset;
  logic [2:0] hold_code, next_hold_code;
  logic [2:0] fade_code, next_fade_code;
  logic [2:0] up_code, next_up_code;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic pwm_s1, pwm_s2, pwm_s3;
  logic tick;
  lcs_state_t state, next_state;
  logic [17:0] cnt, next_cnt;
  logic [2:0] idx, next_idx;
  logic [2:0] next_ref;
  logic [2:0] dac;
  logic [2:0] cur_code;
  logic [17:0] step_len;

  // Register writes; reads never alter state
  always_comb
  begin
    next_sel_low = sel_low;
    next_sel_high = sel_high;
    next_iset = iset;
    next_hold_code = hold_code;
    next_fade_code = fade_code;
    next_up_code = up_code;
    if (i_wr.en)
    begin
      case (i_wr.addr)
        `LCS_ADDR_SEL_LOW: next_sel_low = i_wr.data;
        `LCS_ADDR_SEL_HIGH: next_sel_high = i_wr.data[1:0];
        `LCS_ADDR_FULL_SCALE: next_iset = i_wr.data[`LCS_CODE_MSB:`LCS_CODE_LSB];
        `LCS_ADDR_RAMP_DOWN:
        begin
          next_hold_code = i_wr.data[`LCS_HOLD_MSB:`LCS_HOLD_LSB];
          next_fade_code = i_wr.data[`LCS_CODE_MSB:`LCS_CODE_LSB];
        end
        `LCS_ADDR_RAMP_UP: next_up_code = i_wr.data[`LCS_CODE_MSB:`LCS_CODE_LSB];
        default: next_sel_low = sel_low;
      endcase
    end
    next_rd_valid = i_rd_en;
    next_rd_data = 8'h00;
    if (i_rd_en)
    begin
      case (i_rd_addr)
        `LCS_ADDR_SEL_LOW: next_rd_data = sel_low;
        `LCS_ADDR_SEL_HIGH: next_rd_data = {6'h00, sel_high};
        `LCS_ADDR_FULL_SCALE: next_rd_data = {5'h00, iset};
        `LCS_ADDR_RAMP_DOWN: next_rd_data = {2'h0, hold_code, fade_code};
        `LCS_ADDR_RAMP_UP: next_rd_data = {5'h00, up_code};
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_low <= `LCS_RST_SEL_LOW;
      sel_high <= `LCS_RST_SEL_HIGH;
      iset <= `LCS_RST_FULL_SCALE;
      hold_code <= `LCS_RST_RAMP;
      fade_code <= `LCS_RST_RAMP;
      up_code <= `LCS_RST_RAMP;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      sel_low <= next_sel_low;
      sel_high <= next_sel_high;
      iset <= next_iset;
      hold_code <= next_hold_code;
      fade_code <= next_fade_code;
      up_code <= next_up_code;
      o_rd_data <= next_rd_data;
      o_rd_valid <= next_rd_valid;
    end
  end

  // Half/full select goes straight to the sinks, so a change lands mid-PWM
  assign o_port_full = {sel_high, sel_low};
  assign o_full_scale_code = iset;

  // PWM clock pin is asynchronous; the third stage only feeds the edge detect
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      pwm_s3 <= 1'b0;
    end
    else
    begin
      pwm_s1 <= i_pwm_clk;
      pwm_s2 <= pwm_s1;
      pwm_s3 <= pwm_s2;
    end
  end

  assign tick = pwm_s2 & ~pwm_s3;

  // Every timed phase is eight equal steps; a code doubles the step length
  always_comb
  begin
    case (state)
      ST_HOLD: cur_code = hold_code;
      ST_FADE: cur_code = fade_code;
      default: cur_code = up_code;
    endcase
    step_len = (cur_code == 3'h0) ? P_STEP_TICKS : (P_STEP_TICKS << (cur_code - 3'h1));
  end

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_idx = idx;
    case (state)
      ST_ACTIVE, ST_RAMPUP:
      begin
        if (i_shdn_req)
        begin
          next_cnt = 18'h00000;
          next_idx = 3'h0;
          if (hold_code != 3'h0)
            next_state = ST_HOLD;
          else if (fade_code != 3'h0)
            next_state = ST_FADE;
          else
            next_state = ST_SHDN;
        end
        else if (state == ST_RAMPUP && tick)
        begin
          if (cnt == step_len - 18'h00001)
          begin
            next_cnt = 18'h00000;
            next_idx = idx + 3'h1;
            if (idx == 3'h7)
              next_state = ST_ACTIVE;
          end
          else
            next_cnt = cnt + 18'h00001;
        end
      end
      ST_HOLD, ST_FADE:
      begin
        if (tick)
        begin
          if (cnt == step_len - 18'h00001)
          begin
            next_cnt = 18'h00000;
            next_idx = idx + 3'h1;
            if (idx == 3'h7)
            begin
              if (state == ST_HOLD && fade_code != 3'h0)
                next_state = ST_FADE;
              else
                next_state = ST_SHDN;
            end
          end
          else
            next_cnt = cnt + 18'h00001;
        end
      end
      ST_SHDN:
      begin
        if (i_wake_req)
        begin
          next_cnt = 18'h00000;
          next_idx = 3'h0;
          next_state = (up_code == 3'h0) ? ST_ACTIVE : ST_RAMPUP;
        end
      end
      default: next_state = ST_SHDN;
    endcase
    // Fade walks the scale down, ramp-up walks it up, clipped by full scale
    case (next_state)
      ST_FADE: dac = 3'h7 - next_idx;
      ST_RAMPUP: dac = next_idx;
      ST_SHDN: dac = 3'h0;
      default: dac = 3'h7;
    endcase
    next_ref = (dac < next_iset) ? dac : next_iset;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= ST_SHDN;
      cnt <= 18'h00000;
      idx <= 3'h0;
      o_ref_code <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      o_ref_code <= next_ref;
    end
  end

  assign o_status = '{holdoff: state == ST_HOLD, fadeoff: state == ST_FADE,
                      rampup: state == ST_RAMPUP, shutdown: state == ST_SHDN};

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  sequence seq_last_step;
    tick && idx == 3'h7 && cnt == step_len - 18'h00001;
  endsequence

  AST_SEL_LOW_WR: assert property (i_wr.en && i_wr.addr == `LCS_ADDR_SEL_LOW |=>
    o_port_full[7:0] == $past(i_wr.data)) else $error("port 0-7 select not stored");
  AST_SEL_HIGH_RD: assert property (i_rd_en && i_rd_addr == `LCS_ADDR_SEL_HIGH |=>
    o_rd_data == {6'h00, $past(o_port_full[9:8])}) else $error("port 8-9 readback wrong");
  AST_ISET_RD: assert property (i_rd_en && i_rd_addr == `LCS_ADDR_FULL_SCALE && !i_wr.en
    |=> o_rd_data == {5'h00, o_full_scale_code}) else $error("full scale readback wrong");
  AST_REF_BOUND: assert property (o_ref_code <= o_full_scale_code)
    else $error("reference above full scale");
  AST_HOLD_FULL: assert property (o_status.holdoff |-> o_ref_code == o_full_scale_code)
    else $error("current dropped during hold-off");
  AST_FADE_END: assert property (state == ST_FADE && !i_shdn_req ##0 seq_last_step
    |=> o_status.shutdown && o_ref_code == 3'h0) else $error("fade did not end in shutdown");
  AST_UP_END: assert property (state == ST_RAMPUP && !i_shdn_req ##0 seq_last_step
    |=> state == ST_ACTIVE) else $error("ramp-up did not finish");
  AST_UP_INSTANT: assert property (state == ST_SHDN && i_wake_req && up_code == 3'h0
    |=> state == ST_ACTIVE && o_ref_code == $past(next_iset)) else $error("instant wake failed");
  AST_TICK_ONLY: assert property ((state == ST_HOLD || state == ST_FADE) && !tick
    |=> cnt == $past(cnt) && idx == $past(idx)) else $error("ramp advanced without PWM tick");

endmodule : lcs_top
